// *** inc/wrw_pkg.sv ***
package wrw_pkg;

  // Register map. The printed offset is a word index; the byte address is four times it.
  localparam int          ADDR_W          = 12;
  localparam logic [7:0]  CTRL_IDX        = 8'h2E;
  localparam logic [11:0] CTRL_ADDR       = 12'({4'h0, CTRL_IDX} << 2);
  localparam logic [7:0]  CTRL_RESET      = 8'h7F;
  localparam int          ACTIVE_BIT      = 7;
  localparam int          TOP_BIT         = 6;
  localparam logic [6:0]  COUNT_RESET     = 7'h7F;
  localparam logic [6:0]  COUNT_TRIP      = 7'h40;

  // Clock and timing.
  localparam int          CLK_HZ          = 25_000_000;
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          PRESCALE_CYCLES = 16000;
  localparam int          PIN_LOW_US      = 30;
  localparam int          PIN_LOW_CYCLES  = (PIN_LOW_US * 1000) / CLK_PERIOD_NS;
  localparam int          PHASE_SHORT     = 256;
  localparam int          PHASE_LONG      = 4096;
  localparam int          SEQ_W           = 13;

  // Bus responses.
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0]
  {
    WRW_IDLE  = 2'b00,
    WRW_PIN   = 2'b01,
    WRW_PHASE = 2'b11
  } wrw_state_t;

endpackage

// *** inc/wrw_reg_if.sv ***
`timescale 1ns/1ps
interface wrw_reg_if;
  logic       regWrite;
  logic [7:0] regWdata;
  logic [7:0] regRdata;

  modport slave
  (
    output regWrite,
    output regWdata,
    input  regRdata
  );

  modport core
  (
    input  regWrite,
    input  regWdata,
    output regRdata
  );
endinterface

// *** logic/wrw_axil_slave.sv ***
`timescale 1ns/1ps
module wrw_axil_slave
(
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  // Write channels
  input  wire logic [wrw_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output      logic                      s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output      logic                      s_axi_wready,
  output      logic [1:0]                s_axi_bresp,
  output      logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // Read channels
  input  wire logic [wrw_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output      logic                      s_axi_arready,
  output      logic [31:0]               s_axi_rdata,
  output      logic [1:0]                s_axi_rresp,
  output      logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Core side
  wrw_reg_if.slave                       regPort
);

  logic [wrw_pkg::ADDR_W-1:0] awAddr, next_awAddr;
  logic                       awHeld, next_awHeld;
  logic [7:0]                 wByte, next_wByte;
  logic                       wLane, next_wLane;
  logic                       wHeld, next_wHeld;
  logic                       bValid, next_bValid;
  logic [1:0]                 bResp, next_bResp;
  logic                       rValid, next_rValid;
  logic [31:0]                rData, next_rData;
  logic [1:0]                 rResp, next_rResp;
  logic                       doWrite;
  logic                       wrHit;
  logic                       rdHit;

  assign s_axi_awready = !awHeld && !bValid;
  assign s_axi_wready  = !wHeld && !bValid;
  assign s_axi_arready = !rValid;
  assign s_axi_bvalid  = bValid;
  assign s_axi_bresp   = bResp;
  assign s_axi_rvalid  = rValid;
  assign s_axi_rdata   = rData;
  assign s_axi_rresp   = rResp;

  assign doWrite = awHeld && wHeld;
  assign wrHit   = awAddr[wrw_pkg::ADDR_W-1:2] == wrw_pkg::CTRL_ADDR[wrw_pkg::ADDR_W-1:2];
  assign rdHit   = s_axi_araddr[wrw_pkg::ADDR_W-1:2] == wrw_pkg::CTRL_ADDR[wrw_pkg::ADDR_W-1:2];

  // Only byte lane 0 carries the register; a write without it is answered but stores nothing.
  assign regPort.regWrite = doWrite && wrHit && wLane;
  assign regPort.regWdata = wByte;

  always_comb
  begin
    next_awAddr = awAddr;
    next_awHeld = awHeld;
    next_wByte  = wByte;
    next_wLane  = wLane;
    next_wHeld  = wHeld;
    next_bValid = bValid;
    next_bResp  = bResp;
    next_rValid = rValid;
    next_rData  = rData;
    next_rResp  = rResp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_awAddr = s_axi_awaddr;
      next_awHeld = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_wByte = s_axi_wdata[7:0];
      next_wLane = s_axi_wstrb[0];
      next_wHeld = 1'b1;
    end
    if (doWrite)
    begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bValid = 1'b1;
      next_bResp  = wrHit ? wrw_pkg::RESP_OKAY : wrw_pkg::RESP_SLVERR;
    end
    if (bValid && s_axi_bready)
      next_bValid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rValid = 1'b1;
      next_rData  = rdHit ? {24'h000000, regPort.regRdata} : 32'h00000000;
      next_rResp  = rdHit ? wrw_pkg::RESP_OKAY : wrw_pkg::RESP_SLVERR;
    end
    else if (rValid && s_axi_rready)
      next_rValid = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      awAddr <= '0;
      awHeld <= 1'b0;
      wByte  <= 8'h00;
      wLane  <= 1'b0;
      wHeld  <= 1'b0;
      bValid <= 1'b0;
      bResp  <= 2'h0;
      rValid <= 1'b0;
      rData  <= 32'h00000000;
      rResp  <= 2'h0;
    end
    else
    begin
      awAddr <= next_awAddr;
      awHeld <= next_awHeld;
      wByte  <= next_wByte;
      wLane  <= next_wLane;
      wHeld  <= next_wHeld;
      bValid <= next_bValid;
      bResp  <= next_bResp;
      rValid <= next_rValid;
      rData  <= next_rData;
      rResp  <= next_rResp;
    end
  end

endmodule // wrw_axil_slave

// *** logic/wrw_watchdog.sv ***
// Functional notes
// - Countdown decrements once per 16000 cycles.
// - Active and 40h to 3Fh starts reset.
// - Countdown runs even while inactive.
// - Inactive after reset; writes cannot deactivate.
// - Active bit with top bit clear resets.
// - Halt while active resets unless optioned off.
// - Hardware option makes watchdog always active.
// - Control resets to 7Fh; activation set-only.
// - Register writes never clear the prescaler.
// - Reset phase lasts 256 or 4096 cycles.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module wrw_watchdog
#(
  parameter int PRESCALE_CYCLES = wrw_pkg::PRESCALE_CYCLES
)
(
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       reset_n,
  // AXI4-Lite write channels
  input  wire logic [wrw_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output      logic                       s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output      logic                       s_axi_wready,
  output      logic [1:0]                 s_axi_bresp,
  output      logic                       s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [wrw_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output      logic                       s_axi_arready,
  output      logic [31:0]                s_axi_rdata,
  output      logic [1:0]                 s_axi_rresp,
  output      logic                       s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Option settings and CPU status
  input  wire logic                       hwWatchdogOption,
  input  wire logic                       haltResetDisable,
  input  wire logic                       resetPhaseLong,
  input  wire logic                       haltExec,
  // Reset request towards the system reset circuitry
  output      logic                       watchdogResetReq,
  output      logic                       resetPin_n,
  output      logic                       resetPhase
);

  localparam int PW = $clog2(PRESCALE_CYCLES);
  localparam logic [PW-1:0] PRESCALE_LAST = PW'(PRESCALE_CYCLES - 1);
  localparam logic [wrw_pkg::SEQ_W-1:0] PIN_LAST   = wrw_pkg::SEQ_W'(wrw_pkg::PIN_LOW_CYCLES - 1);
  localparam logic [wrw_pkg::SEQ_W-1:0] SHORT_LAST = wrw_pkg::SEQ_W'(wrw_pkg::PHASE_SHORT - 1);
  localparam logic [wrw_pkg::SEQ_W-1:0] LONG_LAST  = wrw_pkg::SEQ_W'(wrw_pkg::PHASE_LONG - 1);

  wrw_reg_if regBus ();

  wrw_axil_slave u_slave
  (
    .sys_clk       (sys_clk),
    .reset_n       (reset_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .regPort       (regBus.slave)
  );

  logic [PW-1:0]              prescale, next_prescale;
  logic [6:0]                 count, next_count;
  logic                       active, next_active;
  wrw_pkg::wrw_state_t        state, next_state;
  logic [wrw_pkg::SEQ_W-1:0]  seqCount, next_seqCount;
  logic                       phaseLong, next_phaseLong;
  logic                       tick;
  logic                       effActive;
  logic                       writeActive;
  logic                       timeoutTrip;
  logic                       forceTrip;
  logic                       haltTrip;
  logic                       trigger;
  logic                       seqEnd;

  // hardware option
  // The option overrides the stored bit, which then only matters once the option is removed.
  assign effActive   = active || hwWatchdogOption;
  assign writeActive = effActive || regBus.regWdata[wrw_pkg::ACTIVE_BIT];

  assign tick = (prescale == PRESCALE_LAST);

  // timeout trip
  // A write in the same cycle as the tick loads fresh contents, so it cancels that step.
  assign timeoutTrip = effActive && tick && !regBus.regWrite && (count == wrw_pkg::COUNT_TRIP);

  assign forceTrip = regBus.regWrite && writeActive && !regBus.regWdata[wrw_pkg::TOP_BIT];

  assign haltTrip = haltExec && effActive && !haltResetDisable;

  assign trigger = timeoutTrip || forceTrip || haltTrip;
  assign seqEnd  = (state == wrw_pkg::WRW_PHASE) && (seqCount == (phaseLong ? LONG_LAST : SHORT_LAST));

  assign regBus.regRdata = {active, count};

  assign watchdogResetReq = (state != wrw_pkg::WRW_IDLE);
  assign resetPin_n       = (state != wrw_pkg::WRW_PIN);
  assign resetPhase       = (state == wrw_pkg::WRW_PHASE);

  always_comb
  begin
    // prescaler free running
    // Writes leave the prescaler alone, so the first step after a refresh comes at any point of a period.
    next_prescale = tick ? '0 : PW'(prescale + 1'b1);
    next_count    = count;
    next_active   = active;
    if (tick)
      next_count = 7'(count - 7'h01);
    if (regBus.regWrite)
    begin
      next_count  = regBus.regWdata[6:0];
      next_active = active || regBus.regWdata[wrw_pkg::ACTIVE_BIT];
    end
    // The end of the reset phase stands for the system reset that follows it.
    if (seqEnd)
    begin
      next_count  = wrw_pkg::COUNT_RESET;
      next_active = 1'b0;
    end
  end

  always_comb
  begin
    next_state     = state;
    next_seqCount  = seqCount;
    next_phaseLong = phaseLong;
    case (state)
      wrw_pkg::WRW_IDLE:
      begin
        if (trigger)
        begin
          next_state     = wrw_pkg::WRW_PIN;
          next_seqCount  = '0;
          next_phaseLong = resetPhaseLong;
        end
      end
      wrw_pkg::WRW_PIN:
      begin
        if (seqCount == PIN_LAST)
        begin
          next_state    = wrw_pkg::WRW_PHASE;
          next_seqCount = '0;
        end
        else
          next_seqCount = wrw_pkg::SEQ_W'(seqCount + 1'b1);
      end
      wrw_pkg::WRW_PHASE:
      begin
        if (seqEnd)
        begin
          next_state    = wrw_pkg::WRW_IDLE;
          next_seqCount = '0;
        end
        else
          next_seqCount = wrw_pkg::SEQ_W'(seqCount + 1'b1);
      end
      default:
      begin
        next_state    = wrw_pkg::WRW_IDLE;
        next_seqCount = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      prescale  <= '0;
      count     <= wrw_pkg::COUNT_RESET;
      active    <= 1'b0;
      state     <= wrw_pkg::WRW_IDLE;
      seqCount  <= '0;
      phaseLong <= 1'b0;
    end
    else
    begin
      prescale  <= next_prescale;
      count     <= next_count;
      active    <= next_active;
      state     <= next_state;
      seqCount  <= next_seqCount;
      phaseLong <= next_phaseLong;
    end
  end

  // Helper counters of cycles spent with the reset pin low and in the reset phase.
  logic [wrw_pkg::SEQ_W:0] phaseSeen;
  logic [wrw_pkg::SEQ_W:0] pinSeen;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      phaseSeen <= '0;
      pinSeen   <= '0;
    end
    else
    begin
      phaseSeen <= resetPhase ? (wrw_pkg::SEQ_W + 1)'(phaseSeen + 1'b1) : '0;
      pinSeen   <= !resetPin_n ? (wrw_pkg::SEQ_W + 1)'(pinSeen + 1'b1) : '0;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  a_count_step: assert property ((tick && !regBus.regWrite && !seqEnd) |=> (count == 7'($past(count) - 7'h01)))
    else $error("countdown did not step on prescaler tick");

  a_prescale_period: assert property ((tick && !regBus.regWrite && !seqEnd) |=> !tick [*8])
    else $error("prescaler ticked again too soon");

  a_timeout_reset: assert property ((timeoutTrip && state == wrw_pkg::WRW_IDLE) |=> !resetPin_n [*8])
    else $error("timeout did not drive the reset pin low");

  a_pin_low_len: assert property ($rose(resetPin_n) |-> (pinSeen == (wrw_pkg::SEQ_W + 1)'(wrw_pkg::PIN_LOW_CYCLES)))
    else $error("reset pin low time wrong");

  a_inactive_quiet: assert property ((state == wrw_pkg::WRW_IDLE && !effActive
                                      && !(regBus.regWrite && regBus.regWdata[wrw_pkg::ACTIVE_BIT]))
                                     |=> (state == wrw_pkg::WRW_IDLE))
    else $error("inactive watchdog requested a reset");

  a_active_sticky: assert property ((active && !seqEnd) |=> active)
    else $error("activation bit cleared without reset");

  a_force_reset: assert property ((regBus.regWrite && regBus.regWdata[wrw_pkg::ACTIVE_BIT]
                                   && !regBus.regWdata[wrw_pkg::TOP_BIT] && state == wrw_pkg::WRW_IDLE)
                                  |=> (watchdogResetReq && !resetPin_n))
    else $error("forced reset did not start");

  a_halt_reset: assert property ((haltExec && effActive && !haltResetDisable && state == wrw_pkg::WRW_IDLE)
                                 |=> !resetPin_n)
    else $error("halt while active did not reset");

  a_halt_kept: assert property ((haltExec && haltResetDisable && !regBus.regWrite && !tick
                                 && state == wrw_pkg::WRW_IDLE) |=> !watchdogResetReq)
    else $error("halt reset happened although disabled");

  a_hw_option: assert property ((hwWatchdogOption && tick && !regBus.regWrite && count == wrw_pkg::COUNT_TRIP
                                 && state == wrw_pkg::WRW_IDLE) |=> watchdogResetReq)
    else $error("hardware option did not keep watchdog active");

  a_reset_value: assert property (@(posedge sys_clk) disable iff (1'b0)
                                  !reset_n |=> (regBus.regRdata == wrw_pkg::CTRL_RESET))
    else $error("control register reset value wrong");

  a_prescale_kept: assert property ((regBus.regWrite && !tick) |=> (prescale == PW'($past(prescale) + 1'b1)))
    else $error("register write disturbed the prescaler");

  a_phase_len: assert property ($fell(resetPhase) |-> (phaseSeen == (phaseLong
                                 ? (wrw_pkg::SEQ_W + 1)'(wrw_pkg::PHASE_LONG)
                                 : (wrw_pkg::SEQ_W + 1)'(wrw_pkg::PHASE_SHORT))))
    else $error("reset phase length wrong");

  // The checks below pin down single-cycle effects that the bench only sees from outside.
  // All but a_phase_kept and a_phase_follows name the cycle that would hide a fault: a tick, a write or the end of a sequence.
  a_prescale_wrap: assert property (tick |=> (prescale == PW'(0)))
    else $error("prescaler did not restart after its last count");

  a_count_hold: assert property ((!tick && !regBus.regWrite && !seqEnd) |=> (count == $past(count)))
    else $error("countdown moved without a prescaler tick");

  a_cause_only: assert property ((state == wrw_pkg::WRW_IDLE && !haltExec && !regBus.regWrite
                                  && !(tick && count == wrw_pkg::COUNT_TRIP))
                                 |=> (state == wrw_pkg::WRW_IDLE))
    else $error("reset sequence started without a cause");

  a_active_set: assert property ((regBus.regWrite && regBus.regWdata[wrw_pkg::ACTIVE_BIT] && !seqEnd)
                                 |=> active)
    else $error("write of one did not set the activation bit");

  a_seq_restore: assert property (seqEnd |=> (regBus.regRdata == wrw_pkg::CTRL_RESET))
    else $error("control register not restored after the reset phase");

  // A refresh must be safe in any cycle, including one that carries a prescaler tick.
  a_refresh_safe: assert property ((regBus.regWrite && regBus.regWdata[7:6] == 2'h3 && !haltTrip
                                    && state == wrw_pkg::WRW_IDLE) |=> (state == wrw_pkg::WRW_IDLE))
    else $error("refresh write started a reset sequence");

  a_halt_inactive: assert property ((haltExec && !effActive && !regBus.regWrite && !tick
                                     && state == wrw_pkg::WRW_IDLE) |=> !watchdogResetReq)
    else $error("halt reset although the watchdog is inactive");

  // The option overrides the stored bit but must never write it.
  a_hw_stored: assert property ((hwWatchdogOption && regBus.regWrite
                                 && !regBus.regWdata[wrw_pkg::ACTIVE_BIT] && !active) |=> !active)
    else $error("option changed the stored activation bit");

  a_write_load: assert property ((regBus.regWrite && !seqEnd) |=> (count == $past(regBus.regWdata[6:0])))
    else $error("register write did not load the countdown");

  // The phase length is chosen when a sequence starts and must not follow the input later.
  a_phase_kept: assert property ((state != wrw_pkg::WRW_IDLE) |=> $stable(phaseLong))
    else $error("phase length choice changed during a sequence");

  a_phase_follows: assert property ($rose(resetPin_n) |-> resetPhase)
    else $error("reset phase did not follow the pin pulse");

  // Covers for the main ways into a reset sequence, and for a refresh on a prescaler tick.
  c_timeout: cover property (timeoutTrip ##1 !resetPin_n);
  c_force: cover property (forceTrip ##1 watchdogResetReq);
  c_halt: cover property (haltTrip ##1 watchdogResetReq);
  c_refresh: cover property (regBus.regWrite && regBus.regWdata == 8'hFF && tick);
  c_hw_timeout: cover property (hwWatchdogOption && timeoutTrip ##1 !resetPin_n);

endmodule // wrw_watchdog

// *** sim/wrw_watchdog_tb.sv ***
`timescale 1ns/1ps
module wrw_watchdog_tb;
  // A short prescaler keeps the run brief; tick spacings and waits are derived from it, sequence lengths come from the package.
  localparam int          PS    = 16;
  localparam logic [11:0] CADDR = wrw_pkg::CTRL_ADDR;

  logic        sys_clk;
  logic        reset_n;
  logic [11:0] awAddr;
  logic [11:0] arAddr;
  logic [31:0] wData;
  logic [31:0] rData;
  logic [1:0]  bResp;
  logic [1:0]  rResp;
  logic        awValid, awReady, wValid, wReady, bValid, bReady;
  logic        arValid, arReady, rValid, rReady;
  logic        hwOpt, haltOff, phaseLong, haltExec;
  logic        rstReq, rstPin_n, phase;
  int          n_fail;
  int          comparisons;
  int          cyc = 0;

  wrw_watchdog #(.PRESCALE_CYCLES(PS)) dut
  (
    .sys_clk          (sys_clk),
    .reset_n          (reset_n),
    .s_axi_awaddr     (awAddr),
    .s_axi_awvalid    (awValid),
    .s_axi_awready    (awReady),
    .s_axi_wdata      (wData),
    .s_axi_wstrb      (4'hF),
    .s_axi_wvalid     (wValid),
    .s_axi_wready     (wReady),
    .s_axi_bresp      (bResp),
    .s_axi_bvalid     (bValid),
    .s_axi_bready     (bReady),
    .s_axi_araddr     (arAddr),
    .s_axi_arvalid    (arValid),
    .s_axi_arready    (arReady),
    .s_axi_rdata      (rData),
    .s_axi_rresp      (rResp),
    .s_axi_rvalid     (rValid),
    .s_axi_rready     (rReady),
    .hwWatchdogOption (hwOpt),
    .haltResetDisable (haltOff),
    .resetPhaseLong   (phaseLong),
    .haltExec         (haltExec),
    .watchdogResetReq (rstReq),
    .resetPin_n       (rstPin_n),
    .resetPhase       (phase)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    cyc <= cyc + 1;

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic stall(input string what);
    n_fail++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    give_verdict();
  endtask

  // Ready lines stay high, so only the valid lines are released after each handshake.
  task automatic axiWrite(input logic [11:0] a, input logic [7:0] d, output logic [1:0] resp);
    awAddr  <= a;
    wData   <= {24'h0, d};
    awValid <= 1'b1;
    wValid  <= 1'b1;
    for (int k = 0; k < 50; k++)
    begin
      @(posedge sys_clk);
      if (awValid && awReady)
        awValid <= 1'b0;
      if (wValid && wReady)
        wValid <= 1'b0;
      if (bValid)
      begin
        resp = bResp;
        return;
      end
    end
    stall("write response");
  endtask

  task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp, output int hs);
    arAddr  <= a;
    arValid <= 1'b1;
    for (int k = 0; k < 50; k++)
    begin
      @(posedge sys_clk);
      if (arValid && arReady)
      begin
        arValid <= 1'b0;
        hs = cyc;
      end
      if (rValid)
      begin
        d    = rData;
        resp = rResp;
        return;
      end
    end
    stall("read data");
  endtask

  // Waits for a reset sequence, then measures its pin-low and phase lengths edge by edge.
  task automatic seqCheck(input int minWait, input int maxWait, input int phaseLen);
    int n;
    n = 0;
    while (rstPin_n !== 1'b0)
    begin
      if (n == maxWait)
        stall("reset pin low");
      @(posedge sys_clk);
      n++;
    end
    check("pin delay in range", 1, 32'(n >= minWait));
    check("request with pin", 1, rstReq);
    n = 0;
    while (rstPin_n === 1'b0 && n < 9000)
    begin
      @(posedge sys_clk);
      n++;
    end
    check("pin low cycles", wrw_pkg::PIN_LOW_CYCLES, n);
    n = 0;
    while (phase === 1'b1 && n < 9000)
    begin
      @(posedge sys_clk);
      n++;
    end
    check("phase cycles", phaseLen, n);
    check("request released", 0, rstReq);
  endtask

  task automatic haltPulse();
    haltExec <= 1'b1;
    @(posedge sys_clk);
    haltExec <= 1'b0;
  endtask

  task automatic scRegMap();
    logic [31:0] d;
    logic [1:0]  r;
    int          hs;
    axiRead(CADDR, d, r, hs);
    check("control reset value", {24'h0, wrw_pkg::CTRL_RESET}, d);
    check("control read resp", wrw_pkg::RESP_OKAY, r);
    axiRead(12'h004, d, r, hs);
    check("unmapped read resp", wrw_pkg::RESP_SLVERR, r);
    check("unmapped read data", 0, d);
    axiWrite(12'h004, 8'hC0, r);
    check("unmapped write resp", wrw_pkg::RESP_SLVERR, r);
    axiRead(CADDR, d, r, hs);
    check("inactive after reset", 0, d[7]);
  endtask

  task automatic scFreeRun();
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0]  r;
    int          h1;
    int          h2;
    axiRead(CADDR, d, r, h1);
    while (cyc < h1 + 10 * PS - 1)
      @(posedge sys_clk);
    axiRead(CADDR, e, r, h2);
    check("read spacing", 10 * PS, h2 - h1);
    check("ticks while inactive", 10, {25'h0, d[6:0] - e[6:0]});
    // Let the countdown pass 40h to 3Fh with the watchdog still inactive.
    axiWrite(CADDR, 8'h41, r);
    repeat (3 * PS) @(posedge sys_clk);
    check("no reset while inactive", 1, rstPin_n);
  endtask

  task automatic scTimeout();
    logic [31:0] d;
    logic [1:0]  r;
    int          hs;
    axiWrite(CADDR, 8'hC1, r);
    seqCheck(PS, 2 * PS + 2, wrw_pkg::PHASE_SHORT);
    axiRead(CADDR, d, r, hs);
    check("inactive after sequence", 0, d[7]);
  endtask

  task automatic scLockForce();
    logic [31:0] d;
    logic [1:0]  r;
    int          hs;
    axiWrite(CADDR, 8'hFF, r);
    axiWrite(CADDR, 8'h7F, r);
    axiRead(CADDR, d, r, hs);
    check("active bit sticks", 1, d[7]);
    phaseLong <= 1'b1;
    axiWrite(CADDR, 8'h80, r);
    seqCheck(0, 2, wrw_pkg::PHASE_LONG);
    phaseLong <= 1'b0;
  endtask

  task automatic scHalt();
    logic [1:0] r;
    haltPulse();
    repeat (3) @(posedge sys_clk);
    check("halt while inactive", 1, rstPin_n);
    haltOff <= 1'b1;
    axiWrite(CADDR, 8'hFF, r);
    haltPulse();
    repeat (3) @(posedge sys_clk);
    check("halt with option off", 1, rstPin_n);
    haltOff <= 1'b0;
    haltPulse();
    seqCheck(0, 2, wrw_pkg::PHASE_SHORT);
  endtask

  task automatic scHwOption();
    logic [31:0] d;
    logic [1:0]  r;
    int          hs;
    hwOpt <= 1'b1;
    axiWrite(CADDR, 8'h41, r);
    axiRead(CADDR, d, r, hs);
    check("stored active bit", 0, d[7]);
    seqCheck(0, 2 * PS + 2, wrw_pkg::PHASE_SHORT);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    hwOpt   <= 1'b0;
    @(posedge sys_clk);
    axiRead(CADDR, d, r, hs);
    check("control after second reset", {24'h0, wrw_pkg::CTRL_RESET}, d);
  endtask

  initial
  begin
    n_fail      = 0;
    comparisons = 0;
    reset_n     = 1'b0;
    awAddr      = 12'h000;
    arAddr      = 12'h000;
    wData       = 32'h0;
    awValid     = 1'b0;
    wValid      = 1'b0;
    bReady      = 1'b1;
    arValid     = 1'b0;
    rReady      = 1'b1;
    hwOpt       = 1'b0;
    haltOff     = 1'b0;
    phaseLong   = 1'b0;
    haltExec    = 1'b0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    scRegMap();
    scFreeRun();
    scTimeout();
    scLockForce();
    scHalt();
    scHwOption();
    give_verdict();
  end
endmodule // wrw_watchdog_tb
